// *** hw/csbus_write.sv ***
// csbus_write.sv - chip select decode and legacy mode write cycle sequencer
// assumes: core holds a request until accepted; wait pin is asynchronous
//
// Operation
// - An io-configured select fires only during an io instruction.
// - Io decode compares address bits 15:8 with the lower bound for equality.
// - The top address byte is ignored for io decode.
// - The legacy page base is never added to io addresses.
// - Four independent selects, each memory or io.
// - An io select needs both its enable and io-space bits set.
// - Only the lowest-numbered matching select is asserted.
// - Io addresses 0080h to 00FFh go to on-chip peripherals, no select.
// - A memory select fires when the top byte lies within its bounds inclusive.
// - A write cycle has three states plus wait states.
// - State one drives the address and asserts the select.
// - State two asserts the write strobe and the memory or io request strobe.
// - A low wait input seen on the last clock of state two adds waits until it goes high.
// - State three changes no bus signal.
// - Each state lasts 1 to 15 clocks as programmed.
`timescale 1ns/100ps
`include "csbus_params.svh"

module csbus_write #(
   parameter int NUM_CS = `CS_COUNT
) (
   // clock and reset
   input  wire logic                               CLK,
   input  wire logic                               RSTN,
   // core write request
   input  wire logic                               REQ_VALID,
   input  wire csbus_pkg::write_req_t              REQ,
   output logic                                    REQ_READY,
   // settings
   input  wire csbus_pkg::select_cfg_t [NUM_CS-1:0] SELECT_CFG,
   input  wire logic [3:0]                         STATE_LEN,
   // external bus
   output logic [`ADDR_WIDTH-1:0]                  ADDR_OUT,
   output logic [7:0]                              DATA_OUT,
   output logic                                    DATA_OE_N,
   output logic [NUM_CS-1:0]                       CS_N,
   output logic                                    WR_N,
   output logic                                    MEMORY_REQUEST_STROBE_N,
   output logic                                    IO_REQUEST_STROBE_N,
   input  wire logic                               WAIT_N,
   // status
   output logic                                    BUSY,
   output logic                                    IN_WAIT_STATE
);

   // refuse select counts the fixed priority and strobe logic cannot serve
   if (NUM_CS != `CS_COUNT) begin : g_cs_count_check
      $error("csbus_write supports exactly four selects");
   end

   // -----------------------------------------------------------------
   // wait pin synchroniser
   // -----------------------------------------------------------------
   logic [`WAIT_SYNC_STAGES-1:0] wait_sync_reg;
   logic                         wait_low_reg;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wait_sync_reg <= '1;
      end else begin
         wait_sync_reg <= {wait_sync_reg[1:0], WAIT_N};
      end
   end

   // change accepted only when stages two and three agree
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wait_low_reg <= 1'b0;
      end else if (wait_sync_reg[1] == wait_sync_reg[2]) begin
         wait_low_reg <= ~wait_sync_reg[2];
      end
   end

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   logic [NUM_CS-1:0] select_hit;

   cs_decoder #(.NUM_CS(NUM_CS)) u_dec (
      .addr       (REQ.addr),
      .io_cycle   (REQ.io_cycle),
      .cfg        (SELECT_CFG),
      .select_hit (select_hit)
   );

   // -----------------------------------------------------------------
   // state sequencer
   // -----------------------------------------------------------------
   csbus_pkg::bus_state_t state_reg;
   logic [3:0]            cnt_reg;
   logic [3:0]            len_reg;
   logic                  wait_reg;
   logic                  last_clk;
   logic                  take;

   assign last_clk = (cnt_reg == len_reg);
   assign take     = (state_reg == csbus_pkg::ST_IDLE) && REQ_VALID;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_reg <= csbus_pkg::ST_IDLE;
         cnt_reg   <= `STATE_LEN_MIN;
         len_reg   <= `STATE_LEN_RESET;
         wait_reg  <= 1'b0;
      end else begin
         case (state_reg)
            csbus_pkg::ST_IDLE: begin
               cnt_reg  <= `STATE_LEN_MIN;
               wait_reg <= 1'b0;
               if (REQ_VALID) begin
                  // zero length clamps to one clock
                  len_reg   <= (STATE_LEN == 4'h0) ? `STATE_LEN_MIN : STATE_LEN;
                  state_reg <= csbus_pkg::ST_ONE;
               end
            end
            csbus_pkg::ST_ONE: begin
               if (last_clk) begin
                  cnt_reg   <= `STATE_LEN_MIN;
                  state_reg <= csbus_pkg::ST_TWO;
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            csbus_pkg::ST_TWO: begin
               // wait seen on the last clock of state two stretches it
               if (wait_reg) begin
                  if (!wait_low_reg) begin
                     wait_reg  <= 1'b0;
                     cnt_reg   <= `STATE_LEN_MIN;
                     state_reg <= csbus_pkg::ST_THREE;
                  end
               end else if (last_clk) begin
                  cnt_reg <= `STATE_LEN_MIN;
                  if (wait_low_reg) begin
                     wait_reg <= 1'b1;
                  end else begin
                     state_reg <= csbus_pkg::ST_THREE;
                  end
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            csbus_pkg::ST_THREE: begin
               if (last_clk) begin
                  cnt_reg   <= `STATE_LEN_MIN;
                  state_reg <= csbus_pkg::ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            default: begin
               state_reg <= csbus_pkg::ST_IDLE;
               cnt_reg   <= `STATE_LEN_MIN;
               wait_reg  <= 1'b0;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // bus outputs
   // -----------------------------------------------------------------
   logic io_reg;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         ADDR_OUT  <= '0;
         DATA_OUT  <= 8'h00;
         DATA_OE_N <= 1'b1;
         CS_N      <= '1;
         io_reg    <= 1'b0;
      end else if (take) begin
         ADDR_OUT  <= REQ.addr;
         DATA_OUT  <= REQ.data;
         DATA_OE_N <= 1'b0;
         CS_N      <= ~select_hit;
         io_reg    <= REQ.io_cycle;
      end else if (state_reg == csbus_pkg::ST_THREE && last_clk) begin
         DATA_OE_N <= 1'b1;
         CS_N      <= '1;
      end
   end

   // strobes: asserted entering state two, held through three
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         WR_N                    <= 1'b1;
         MEMORY_REQUEST_STROBE_N <= 1'b1;
         IO_REQUEST_STROBE_N     <= 1'b1;
      end else if (state_reg == csbus_pkg::ST_ONE && last_clk) begin
         WR_N                    <= 1'b0;
         MEMORY_REQUEST_STROBE_N <= io_reg;
         IO_REQUEST_STROBE_N     <= ~io_reg;
      end else if (state_reg == csbus_pkg::ST_THREE && last_clk) begin
         WR_N                    <= 1'b1;
         MEMORY_REQUEST_STROBE_N <= 1'b1;
         IO_REQUEST_STROBE_N     <= 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         REQ_READY     <= 1'b0;
         BUSY          <= 1'b0;
         IN_WAIT_STATE <= 1'b0;
      end else begin
         REQ_READY     <= take;
         BUSY          <= (state_reg != csbus_pkg::ST_IDLE) || take;
         IN_WAIT_STATE <= (state_reg == csbus_pkg::ST_TWO) &&
                          (wait_reg ? wait_low_reg : (last_clk && wait_low_reg));
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_three_stable: assert property (@(posedge CLK) disable iff (!RSTN)
      (state_reg == csbus_pkg::ST_THREE && !last_clk) |=>
         ($stable(ADDR_OUT) && $stable(CS_N) && $stable(WR_N)))
      else $error("bus signal changed in state three");

   a_onehot_select: assert property (@(posedge CLK) disable iff (!RSTN)
      $onehot0(~CS_N))
      else $error("more than one select active");

   a_io_select_type: assert property (@(posedge CLK) disable iff (!RSTN)
      (take && REQ.io_cycle && select_hit != '0) |->
         (SELECT_CFG[$clog2(select_hit)].select_control[`CTL_IO_BIT]))
      else $error("memory select fired on io cycle");

   a_periph_range: assert property (@(posedge CLK) disable iff (!RSTN)
      (take && REQ.io_cycle && REQ.addr[15:0] >= `PERIPH_IO_LO &&
       REQ.addr[15:0] <= `PERIPH_IO_HI) |=> (CS_N == '1))
      else $error("select asserted in peripheral range");

   a_strobe_after_one: assert property (@(posedge CLK) disable iff (!RSTN)
      (take && STATE_LEN == 4'h1) |=> WR_N ##1 !WR_N)
      else $error("write strobe not asserted in state two");

   a_strobe_excl: assert property (@(posedge CLK) disable iff (!RSTN)
      !(!MEMORY_REQUEST_STROBE_N && !IO_REQUEST_STROBE_N))
      else $error("both request strobes active");

   a_wait_hold: assert property (@(posedge CLK) disable iff (!RSTN)
      (state_reg == csbus_pkg::ST_TWO && wait_reg && wait_low_reg) |=>
         (state_reg == csbus_pkg::ST_TWO))
      else $error("left state two during wait");

   a_release_end: assert property (@(posedge CLK) disable iff (!RSTN)
      (state_reg == csbus_pkg::ST_THREE && last_clk) |=>
         (WR_N && CS_N == '1 && MEMORY_REQUEST_STROBE_N && IO_REQUEST_STROBE_N))
      else $error("strobes not released after state three");

   a_min_cycle: assert property (@(posedge CLK) disable iff (!RSTN)
      (take && STATE_LEN == 4'h1 && !wait_low_reg) |=>
         (state_reg == csbus_pkg::ST_ONE) ##1 (state_reg == csbus_pkg::ST_TWO))
      else $error("state sequence wrong");

   c_mem_write: cover property (@(posedge CLK) take && !REQ.io_cycle && select_hit != '0);
   c_io_write:  cover property (@(posedge CLK) take && REQ.io_cycle && select_hit != '0);
   c_wait:      cover property (@(posedge CLK) IN_WAIT_STATE);
   c_long:      cover property (@(posedge CLK) take && STATE_LEN == 4'hf);

endmodule // csbus_write

// *** common/csbus_params.svh ***
// csbus_params.svh - constants for the chip select decoder and write cycle logic
// assumes: included by the package and design files by bare name
`ifndef CSBUS_PARAMS_SVH
`define CSBUS_PARAMS_SVH

// -----------------------------------------------------------------
// address decode
// -----------------------------------------------------------------
`define CS_COUNT          4
`define ADDR_WIDTH        24
`define IO_HI_MSB         15
`define IO_HI_LSB         8
`define MEM_HI_MSB        23
`define MEM_HI_LSB        16
`define PERIPH_IO_LO      16'h0080
`define PERIPH_IO_HI      16'h00ff

// -----------------------------------------------------------------
// select control fields
// -----------------------------------------------------------------
`define CTL_EN_BIT        3
`define CTL_IO_BIT        4

// -----------------------------------------------------------------
// bus state timing
// -----------------------------------------------------------------
`define STATE_LEN_MIN     4'h1
`define STATE_LEN_MAX     4'hf
`define STATE_LEN_RESET   4'h1
`define WAIT_SYNC_STAGES  3

`endif

// *** common/csbus_pkg.sv ***
// csbus_pkg.sv - types shared by the chip select decoder and write cycle logic
// assumes: csbus_params.svh on the include path
`include "csbus_params.svh"

package csbus_pkg;

   // per select settings
   typedef struct packed {
      logic [7:0] select_lower_bound;
      logic [7:0] select_upper_bound;
      logic [7:0] select_control;
   } select_cfg_t;

   // write request from the core
   typedef struct packed {
      logic                       io_cycle;
      logic [`ADDR_WIDTH-1:0]     addr;
      logic [7:0]                 data;
   } write_req_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ONE   = 4'b0010,
      ST_TWO   = 4'b0100,
      ST_THREE = 4'b1000
   } bus_state_t;

endpackage

// *** hw/cs_decoder.sv ***
// cs_decoder.sv - combinational chip select decode with fixed priority
// assumes: address and cycle type stable while the result is sampled
`timescale 1ns/100ps
`include "csbus_params.svh"

module cs_decoder #(
   parameter int NUM_CS = `CS_COUNT
) (
   // decode request
   input  wire logic [`ADDR_WIDTH-1:0]        addr,
   input  wire logic                          io_cycle,
   // settings
   input  wire csbus_pkg::select_cfg_t [NUM_CS-1:0] cfg,
   // result, one hot or zero
   output logic [NUM_CS-1:0]                  select_hit
);

   logic [NUM_CS-1:0] match;
   logic              periph_range;

   // on-chip peripherals own this range; page base never applied to io
   assign periph_range = io_cycle && (addr[15:0] >= `PERIPH_IO_LO) &&
                         (addr[15:0] <= `PERIPH_IO_HI);

   for (genvar i = 0; i < NUM_CS; i++) begin : g_match
      logic en;
      logic io;
      assign en = cfg[i].select_control[`CTL_EN_BIT];
      assign io = cfg[i].select_control[`CTL_IO_BIT];
      // io compare uses only address bits 15:8, top byte ignored
      assign match[i] = en && (io ?
         (io_cycle && !periph_range &&
          addr[`IO_HI_MSB:`IO_HI_LSB] == cfg[i].select_lower_bound) :
         (!io_cycle &&
          addr[`MEM_HI_MSB:`MEM_HI_LSB] >= cfg[i].select_lower_bound &&
          addr[`MEM_HI_MSB:`MEM_HI_LSB] <= cfg[i].select_upper_bound));
   end

   // lowest number wins
   assign select_hit = match & ~(match - NUM_CS'(1));

endmodule // cs_decoder

// *** testbench/csbus_far_device.sv ***
// csbus_far_device.sv - behavioural external peripheral on the write bus
// assumes: active-low selects and write strobe from the sequencer, one clock
`timescale 1ns/100ps

module csbus_far_device (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // bus from the sequencer
   input  wire logic [3:0] cs_n,
   input  wire logic       wr_n,
   input  wire logic [7:0] data_in,
   // stretch request, low wait cycles per access
   input  wire logic [3:0] wait_len,
   output logic            wait_n,
   // last byte accepted
   output logic [7:0]      seen_data
);
   logic [3:0] wait_cnt_reg;
   logic       selected_reg;

   // wait starts at select, well ahead of the end of state two
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wait_cnt_reg <= 4'h0;
         selected_reg <= 1'b0;
      end else begin
         selected_reg <= (cs_n != 4'hf);
         if ((cs_n != 4'hf) && !selected_reg) begin
            wait_cnt_reg <= wait_len;
         end else if (wait_cnt_reg != 4'h0) begin
            wait_cnt_reg <= wait_cnt_reg - 4'h1;
         end
      end
   end

   assign wait_n = (wait_cnt_reg == 4'h0);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         seen_data <= 8'h00;
      end else if (!wr_n && (cs_n != 4'hf)) begin
         seen_data <= data_in;
      end
   end
endmodule // csbus_far_device

// *** testbench/csbus_write_test.sv ***
// csbus_write_test.sv - self-checking bench for the select decode and write cycle
// assumes: csbus_far_device answers on the bus side
`timescale 1ns/100ps
`include "csbus_params.svh"

module csbus_write_test;
   logic                         CLK;
   logic                         RSTN;
   logic                         REQ_VALID;
   csbus_pkg::write_req_t        REQ;
   logic                         REQ_READY;
   csbus_pkg::select_cfg_t [3:0] SELECT_CFG;
   logic [3:0]                   STATE_LEN;
   logic [23:0]                  ADDR_OUT;
   logic [7:0]                   DATA_OUT;
   logic                         DATA_OE_N;
   logic [3:0]                   CS_N;
   logic                         WR_N;
   logic                         MEMORY_REQUEST_STROBE_N;
   logic                         IO_REQUEST_STROBE_N;
   logic                         WAIT_N;
   logic                         BUSY;
   logic                         IN_WAIT_STATE;
   logic [3:0]                   wait_len;
   logic [7:0]                   seen_data;
   logic [3:0]                   cs_seen;
   logic                         mem_strobe_seen;
   logic                         io_strobe_seen;
   logic                         wait_seen;
   int                           cs_cnt;
   int                           wr_cnt;
   int                           wr_at;
   int                           mismatches;
   int                           checked;

   csbus_write u_csbus_write (.CLK(CLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID), .REQ(REQ),
      .REQ_READY(REQ_READY), .SELECT_CFG(SELECT_CFG), .STATE_LEN(STATE_LEN),
      .ADDR_OUT(ADDR_OUT), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .CS_N(CS_N),
      .WR_N(WR_N), .MEMORY_REQUEST_STROBE_N(MEMORY_REQUEST_STROBE_N),
      .IO_REQUEST_STROBE_N(IO_REQUEST_STROBE_N), .WAIT_N(WAIT_N), .BUSY(BUSY),
      .IN_WAIT_STATE(IN_WAIT_STATE));

   csbus_far_device u_csbus_far_device (.clk(CLK), .rstn(RSTN), .cs_n(CS_N), .wr_n(WR_N),
      .data_in(DATA_OUT), .wait_len(wait_len), .wait_n(WAIT_N), .seen_data(seen_data));

   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end

   // ------------------------------------------------
   // shared tasks
   // ------------------------------------------------
   task automatic conclude();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   function automatic csbus_pkg::select_cfg_t cfg(input logic [7:0] lo, hi, ctl);
      return '{select_lower_bound: lo, select_upper_bound: hi, select_control: ctl};
   endfunction

   // one write; judges select, strobes, held bus and released bus
   task automatic bus_write(input logic io, input logic [23:0] a, input logic [7:0] d,
                            input logic [3:0] exp_cs);
      int n;
      n = 0;
      cs_seen = 4'hf;
      cs_cnt = 0;
      wr_cnt = 0;
      wr_at = -1;
      {mem_strobe_seen, io_strobe_seen, wait_seen} = 3'b000;
      REQ = '{io_cycle: io, addr: a, data: d};
      REQ_VALID = 1'b1;
      do begin
         @(posedge CLK);
         #1;
         n++;
      end while (REQ_READY !== 1'b1 && n < 20);
      // request never taken: give up and report
      if (REQ_READY !== 1'b1) begin
         mismatches++;
         conclude();
      end
      while (BUSY === 1'b1 && n < 200) begin
         if (CS_N !== 4'hf) cs_seen = CS_N;
         if (CS_N !== 4'hf) cs_cnt++;
         if (WR_N === 1'b0 && wr_cnt == 0) wr_at = cs_cnt - 1;
         if (WR_N === 1'b0) wr_cnt++;
         if (WR_N === 1'b0) check(ADDR_OUT === a && CS_N === cs_seen, "bus moved");
         if (WR_N === 1'b0) check(DATA_OE_N === 1'b0 && DATA_OUT === d, "data driven");
         mem_strobe_seen |= (MEMORY_REQUEST_STROBE_N === 1'b0);
         io_strobe_seen |= (IO_REQUEST_STROBE_N === 1'b0);
         wait_seen |= (IN_WAIT_STATE === 1'b1);
         @(posedge CLK);
         #1;
         n++;
         REQ_VALID = 1'b0;
      end
      if (n >= 200) begin
         mismatches++;
         conclude();
      end
      check(cs_seen === exp_cs, "select");
      check(io_strobe_seen === io && mem_strobe_seen === !io, "request strobe");
      check(&{CS_N, WR_N, DATA_OE_N}, "select released");
      check(MEMORY_REQUEST_STROBE_N && IO_REQUEST_STROBE_N, "strobes released");
      check(wait_seen === (wait_len != 4'h0), "wait state flag");
      if (exp_cs !== 4'hf) check(seen_data === d, "data");
   endtask

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_memory_decode();
      SELECT_CFG[0] = cfg(8'h00, 8'h7f, 8'h08);
      SELECT_CFG[1] = cfg(8'h00, 8'h9f, 8'h08);
      SELECT_CFG[2] = cfg(8'ha0, 8'hcf, 8'h08);
      SELECT_CFG[3] = cfg(8'hd0, 8'hff, 8'h08);
      bus_write(1'b0, 24'h123456, 8'h5a, 4'he);
      bus_write(1'b0, 24'h7fffff, 8'ha5, 4'he);
      bus_write(1'b0, 24'h800000, 8'h01, 4'hd);
      bus_write(1'b0, 24'h9fffff, 8'h02, 4'hd);
      bus_write(1'b0, 24'ha00000, 8'h03, 4'hb);
      bus_write(1'b0, 24'hcfffff, 8'h04, 4'hb);
      bus_write(1'b0, 24'hd00000, 8'h05, 4'h7);
      bus_write(1'b0, 24'hffffff, 8'h06, 4'h7);
      bus_write(1'b1, 24'h001234, 8'h07, 4'hf);
      SELECT_CFG[2] = cfg(8'ha0, 8'hcf, 8'h00);
      bus_write(1'b0, 24'hb00000, 8'h08, 4'hf);
   endtask

   task automatic t_io_decode();
      SELECT_CFG[0] = cfg(8'h00, 8'hff, 8'h08);
      SELECT_CFG[1] = cfg(8'h12, 8'h00, 8'h10);
      SELECT_CFG[2] = cfg(8'h12, 8'h00, 8'h18);
      SELECT_CFG[3] = cfg(8'h00, 8'h00, 8'h18);
      bus_write(1'b1, 24'hab12cd, 8'h11, 4'hb);
      bus_write(1'b1, 24'h000080, 8'h12, 4'hf);
      bus_write(1'b1, 24'h0000ff, 8'h13, 4'hf);
      bus_write(1'b1, 24'hff007f, 8'h14, 4'h7);
      bus_write(1'b1, 24'h000100, 8'h15, 4'hf);
      bus_write(1'b0, 24'h0012cd, 8'h16, 4'he);
   endtask

   task automatic t_state_len();
      logic [3:0] lens [4];
      int eff;
      lens = '{4'h0, 4'h1, 4'h2, 4'hf};
      foreach (lens[i]) begin
         STATE_LEN = lens[i];
         eff = (lens[i] == 4'h0) ? 1 : int'(lens[i]);
         bus_write(1'b0, 24'h000010, 8'h20, 4'he);
         check(cs_cnt == 3 * eff, "cycle length");
         check(wr_cnt == 2 * eff, "strobe length");
         check(wr_at == eff, "first state");
      end
   endtask

   task automatic t_wait();
      STATE_LEN = 4'h4;
      wait_len = 4'hc;
      bus_write(1'b0, 24'h000020, 8'h30, 4'he);
      check(wait_seen === 1'b1, "no wait state");
      check(wr_cnt > 10 && wr_cnt < 26, "stretched length");
      check(cs_cnt == wr_cnt + 4, "first state with wait");
      wait_len = 4'h0;
      STATE_LEN = 4'h1;
   endtask

   initial begin
      mismatches = 0;
      checked = 0;
      RSTN = 1'b0;
      REQ_VALID = 1'b0;
      REQ = '0;
      SELECT_CFG = '0;
      STATE_LEN = 4'h1;
      wait_len = 4'h0;
      repeat (16) @(posedge CLK);
      #1;
      RSTN = 1'b1;
      t_memory_decode();
      t_io_decode();
      t_state_len();
      t_wait();
      conclude();
   end
endmodule // csbus_write_test
